// file: bench/sacs_host.sv
// Host serial controller model for the converter's serial link
`timescale 1ns/1ps
`default_nettype none
module sacs_host (
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic conversion_strobe
);
    logic [63:0] rx_d;
    logic [63:0] rx_s;
    initial begin
        serial_clk = 1'b0;
        chip_select_n = 1'b0;
        serial_data_in = 1'b0;
        // Select rises after time zero so the link reset sees an edge
        #1;
        chip_select_n = 1'b1;
    end
    task automatic select(input logic level);
        chip_select_n <= level;
        #100;
    endtask
    // ****************************************************************
    // One frame of n clocks, bit i sent on rise i+1
    // ****************************************************************
    // Clock stands low between frames; frames end far inside 1ms
    // Limitation: 48ns link period, above the 2MHz readout ceiling
    task automatic frame(input logic [63:0] tx, input int n);
        for (int i = 0; i < n; i++) begin
            serial_data_in <= tx[i];
            #4;
            serial_clk <= ~serial_clk;
            #24;
            serial_clk <= ~serial_clk;
            #20;
            rx_d[i] = serial_data_out;
            rx_s[i] = conversion_strobe;
        end
        serial_data_in <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// Testbench of the serial converter sequencer against a reference model
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sacs_pkg::*;
    localparam int CONV = 200;
    logic ref_clk, reset, serial_clk, chip_select_n, serial_data_in;
    logic hard_shutdown_input_low, hard_shutdown_input_high, hard_shutdown_input_float;
    logic serial_data_out, serial_data_out_oe, conversion_strobe, conversion_strobe_oe;
    logic input_config_select, polarity_select, power_up, reference_enable, uni;
    sacs_byte_t analog_code, code, res, ctl;
    sacs_chan_t channel_select, ch;
    int fails = 0;
    int comparisons = 0;
    int seed = 20812;
    int lowrun, sp, n;
    logic [63:0] tx, ed, es;
    sacs_sequencer #(.CONV_CYCLES(CONV)) sacs_sequencer_inst (
        .ref_clk(ref_clk), .reset(reset), .serial_clk(serial_clk),
        .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
        .analog_code(analog_code), .hard_shutdown_input_low(hard_shutdown_input_low),
        .hard_shutdown_input_high(hard_shutdown_input_high),
        .hard_shutdown_input_float(hard_shutdown_input_float),
        .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
        .conversion_strobe(conversion_strobe), .conversion_strobe_oe(conversion_strobe_oe),
        .channel_select(channel_select), .input_config_select(input_config_select),
        .polarity_select(polarity_select), .power_up(power_up),
        .reference_enable(reference_enable));
    sacs_host sacs_host_inst (
        .serial_clk(serial_clk), .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .conversion_strobe(conversion_strobe));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic set_shutdown(input logic [2:0] lvl);
        @(posedge ref_clk);
        hard_shutdown_input_low <= lvl[2];
        hard_shutdown_input_high <= lvl[1];
        hard_shutdown_input_float <= lvl[0];
        repeat (6) @(posedge ref_clk);
    endtask
    function automatic logic [63:0] place(logic [63:0] v, sacs_byte_t b, int at);
        for (int j = 0; j < 8; j++) begin
            v[at + j] = b[7 - j];
        end
        return v;
    endfunction
    // New random sample and control fields; result coding per polarity
    task automatic pick(input logic pwr, input logic ext);
        code = 8'($random(seed));
        ch = 3'($random(seed));
        uni = 1'($random(seed));
        res = uni ? code : code ^ 8'h80;
        ctl = {1'b1, ch, uni, 1'b1, pwr, ext};
        @(posedge ref_clk);
        analog_code <= code;
        repeat (4) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (conversion_strobe === 1'b0) begin
            lowrun <= lowrun + 1;
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #200_000;
        fails++;
        stop_test();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        // Reset rises after time zero so every asynchronous reset sees its edge
        reset = 1'b0;
        analog_code = 8'h00;
        #1;
        reset = 1'b1;
        set_shutdown(3'b010);
        repeat (13) @(posedge ref_clk);
        check({5'h0, conversion_strobe, conversion_strobe_oe, serial_data_out}, 8'h06);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({7'h0, power_up}, 8'h01);
        // Internal clock conversion with power-down requested
        pick(1'b0, 1'b0);
        sacs_host_inst.select(1'b0);
        sacs_host_inst.frame(place(64'h0, ctl, 0), 8);
        sacs_host_inst.select(1'b1);
        check({6'h0, conversion_strobe_oe, serial_data_out_oe}, 8'h02);
        check({6'h0, conversion_strobe, power_up}, 8'h01);
        for (int k = 0; k < CONV + 50 && conversion_strobe !== 1'b1; k++) begin
            @(posedge ref_clk);
        end
        repeat (40) @(posedge ref_clk);
        check(8'(lowrun >= CONV - 2 && lowrun <= CONV + 3), 8'h01);
        check({7'h0, power_up}, 8'h00);
        sacs_host_inst.select(1'b0);
        sacs_host_inst.frame(64'h0, 16);
        sacs_host_inst.select(1'b1);
        ed = place(64'h0, res, 1);
        for (int i = 0; i < 16; i++) begin
            check({7'h0, sacs_host_inst.rx_d[i]}, {7'h0, ed[i]});
        end
        // External clock: abort, then three overlapped conversions
        for (int s = 0; s < 2; s++) begin
            pick(1'b1, 1'b1);
            sp = s ? 16 : 10;
            n = 3 * sp + 16;
            tx = 64'h0;
            ed = 64'h0;
            es = 64'h0;
            for (int k = 0; k < 3; k++) begin
                tx = place(tx, ctl, k * sp);
                ed = place(ed, res, k * sp + 9);
                es[k * sp + 7] = 1'b1;
                es[k * sp + 8] = 1'b1;
            end
            sacs_host_inst.select(1'b0);
            sacs_host_inst.frame(tx, 10);
            check({7'h0, power_up}, 8'h01);
            sacs_host_inst.select(1'b1);
            check({6'h0, conversion_strobe_oe, serial_data_out_oe}, 8'h00);
            sacs_host_inst.select(1'b0);
            check({6'h0, conversion_strobe, conversion_strobe_oe}, 8'h01);
            sacs_host_inst.frame(tx, n);
            sacs_host_inst.select(1'b1);
            for (int i = 0; i < n; i++) begin
                check({7'h0, sacs_host_inst.rx_d[i]}, {7'h0, ed[i]});
                check({7'h0, sacs_host_inst.rx_s[i]}, {7'h0, es[i]});
            end
            check({3'h0, channel_select, polarity_select, input_config_select}, {3'h0, ch, uni, 1'b1});
        end
        // Hard shutdown during an internal conversion, then each pin level
        pick(1'b1, 1'b0);
        sacs_host_inst.select(1'b0);
        sacs_host_inst.frame(place(64'h0, ctl, 0), 8);
        sacs_host_inst.select(1'b1);
        set_shutdown(3'b100);
        check({7'h0, power_up}, 8'h00);
        for (int l = 0; l < 3; l++) begin
            set_shutdown(3'b100 >> l);
            check({6'h0, power_up, reference_enable}, {6'h0, l != 0, l == 2});
        end
        stop_test();
    end
endmodule
`default_nettype wire

// file: hw/sacs_pkg.sv
// Types of the serial converter sequencer
package sacs_pkg;
    typedef logic [7:0] sacs_byte_t;
    typedef logic [2:0] sacs_chan_t;
    typedef enum logic [0:0] {
        SACS_FR_HUNT = 1'b0,
        SACS_FR_CTRL = 1'b1
    } sacs_frame_e;
    typedef enum logic [0:0] {
        SACS_CV_IDLE = 1'b0,
        SACS_CV_RUN = 1'b1
    } sacs_conv_e;
endpackage

// file: hw/sacs_regs.svh
// Constants of the serial converter sequencer: control byte fields, counts and reset values
`ifndef SACS_REGS_SVH
`define SACS_REGS_SVH

// ****************************************************************
// Control byte fields
// ****************************************************************
`define SACS_CTRL_CHAN_HI 6
`define SACS_CTRL_CHAN_LO 4
`define SACS_CTRL_POLARITY_BIT 3
`define SACS_CTRL_CONFIG_BIT 2
`define SACS_CTRL_POWER_BIT 1
`define SACS_CTRL_CLOCK_BIT 0
`define SACS_CTRL_LAST_CNT 3'h6

// ****************************************************************
// Timing
// ****************************************************************
`define SACS_REF_CLK_NS 10
`define SACS_CONV_TIME_NS 25000
`define SACS_CONV_CYCLES (`SACS_CONV_TIME_NS / `SACS_REF_CLK_NS)

// ****************************************************************
// Output sequence steps, one per falling serial clock edge
// ****************************************************************
`define SACS_STEP_IDLE 4'h0
`define SACS_STEP_STROBE 4'h1
`define SACS_STEP_HOLD 4'h2
`define SACS_STEP_MSB 4'h3
`define SACS_STEP_LSB 4'ha
`define SACS_STEP_DONE 4'hb

// ****************************************************************
// Reset values
// ****************************************************************
`define SACS_RESULT_RST 8'h00
`define SACS_CTRL_RST 8'h00

`endif

// file: hw/sacs_sequencer.sv
// Serial interface and conversion sequencer of an 8-bit multi-channel converter
`timescale 1ns/1ps
`default_nettype none
`include "sacs_regs.svh"

// Function
// [RULE1] External mode: strobe high two clocks after byte
// [RULE2] External mode: eight result bits, MSB first
// [RULE3] Zeros shifted out after the result
// [RULE4] External mode: select high floats strobe, data
// [RULE5] Host finishes external conversion within 1ms
// [RULE6] Internal mode: strobe low during 25us conversion
// [RULE7] Host keeps serial clock low meanwhile
// [RULE8] Internal result held, MSB on second fall
// [RULE9] Select high blocks input, floats data only
// [RULE10] Internal mode: strobe always driven
// [RULE11] Host shifts up to 2MHz internally
// [RULE12] First high bit after select is start
// [RULE13] Conversion starts on fall after eighth bit
// [RULE14] Start accepted when idle or MSB out
// [RULE15] Select toggle aborts; next high bit starts
// [RULE16] Overlapped operation at ten clocks per conversion
// [RULE17] Power-on: internal mode, strobe high, zeros
// [RULE18] Shutdown low powers down, overrides power bit
// [RULE19] Power-down request finishes current conversion first
// [RULE20] Start bit wakes; power bit decides staying awake
// [RULE21] Shutdown low halts conversion at once
// [RULE22] Shutdown level selects operation and reference
// [RULE23] Bit0 clock mode, bit1 power mode
// [RULE24] Rising serial clock shifts input in
// [RULE25] Unipolar straight binary, bipolar two's complement
// [RULE26] Shutdown pin arrives as decoded indications
module sacs_sequencer #(
    parameter int CONV_CYCLES = `SACS_CONV_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    input wire sacs_pkg::sacs_byte_t analog_code,
    input wire logic hard_shutdown_input_low,
    input wire logic hard_shutdown_input_high,
    input wire logic hard_shutdown_input_float,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic conversion_strobe,
    output logic conversion_strobe_oe,
    output sacs_pkg::sacs_chan_t channel_select,
    output logic input_config_select,
    output logic polarity_select,
    output logic power_up,
    output logic reference_enable
);
    import sacs_pkg::*;

    // ****************************************************************
    // Shared helpers
    // ****************************************************************
    function automatic sacs_byte_t fmt_code(input sacs_byte_t code, input logic unipolar);
        fmt_code = unipolar ? code : {~code[7], code[6:0]}; // [RULE25]
    endfunction

    // Select high clears framing and the external sequence at once
    logic link_rst;
    assign link_rst = reset | chip_select_n; // [RULE15]

    // ****************************************************************
    // Link domain, rising edge: input framing
    // ****************************************************************
    sacs_frame_e fr_q, fr_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic [5:0] ctrl_sh_q, ctrl_sh_d;
    logic launch_tgl_q, launch_tgl_d;
    sacs_byte_t ctrl_word_q, ctrl_word_d;
    sacs_byte_t code_snap_q, code_snap_d;
    sacs_byte_t an_s1_q, an_s2_q;
    logic dn_s1_q, dn_s2_q, sh_s1_q, sh_s2_q;
    logic done_tgl_q;
    logic [3:0] step_q;
    logic hunt_ok;

    always_comb begin
        // Overlap: a new start bit may arrive once the MSB is out
        hunt_ok = (step_q == `SACS_STEP_IDLE) || (step_q >= `SACS_STEP_MSB); // [RULE14] [RULE16]
        fr_d = fr_q;
        bit_cnt_d = bit_cnt_q;
        ctrl_sh_d = ctrl_sh_q;
        launch_tgl_d = launch_tgl_q;
        ctrl_word_d = ctrl_word_q;
        code_snap_d = code_snap_q;
        unique case (fr_q)
            SACS_FR_HUNT: begin
                // Zeros before the start bit have no effect
                if (serial_data_in && hunt_ok) begin // [RULE12]
                    fr_d = SACS_FR_CTRL;
                    bit_cnt_d = 3'h0;
                end
            end
            SACS_FR_CTRL: begin
                ctrl_sh_d = {ctrl_sh_q[4:0], serial_data_in}; // [RULE24]
                bit_cnt_d = bit_cnt_q + 3'h1;
                if (bit_cnt_q == `SACS_CTRL_LAST_CNT) begin
                    fr_d = SACS_FR_HUNT;
                    launch_tgl_d = ~launch_tgl_q; // [RULE13]
                    ctrl_word_d = {1'b1, ctrl_sh_q, serial_data_in};
                    code_snap_d = an_s2_q;
                end
            end
        endcase
    end

    always_ff @(posedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            fr_q <= SACS_FR_HUNT;
            bit_cnt_q <= 3'h0;
            ctrl_sh_q <= 6'h00;
        end else begin
            fr_q <= fr_d;
            bit_cnt_q <= bit_cnt_d;
            ctrl_sh_q <= ctrl_sh_d;
        end
    end

    // Toggles and their data survive select toggling, so crossings stay paired
    always_ff @(posedge serial_clk or posedge reset) begin
        if (reset) begin
            launch_tgl_q <= 1'b0;
            ctrl_word_q <= `SACS_CTRL_RST;
            code_snap_q <= `SACS_RESULT_RST;
            an_s1_q <= `SACS_RESULT_RST;
            an_s2_q <= `SACS_RESULT_RST;
            dn_s1_q <= 1'b0;
            dn_s2_q <= 1'b0;
            sh_s1_q <= 1'b0;
            sh_s2_q <= 1'b0;
        end else begin
            launch_tgl_q <= launch_tgl_d;
            ctrl_word_q <= ctrl_word_d;
            code_snap_q <= code_snap_d;
            an_s1_q <= analog_code;
            an_s2_q <= an_s1_q;
            dn_s1_q <= done_tgl_q;
            dn_s2_q <= dn_s1_q;
            sh_s1_q <= hard_shutdown_input_low;
            sh_s2_q <= sh_s1_q;
        end
    end

    // ****************************************************************
    // Link domain, falling edge: strobe and data output sequence
    // ****************************************************************
    logic [3:0] step_d;
    logic launch_seen_q, launch_seen_d, rd_seen_q, rd_seen_d;
    sacs_byte_t out_word_q, out_word_d;
    sacs_byte_t result_q;
    logic dout_q, dout_d, ext_strobe_q, ext_strobe_d, link_busy_q, link_busy_d;
    logic [2:0] bit_idx;

    always_comb begin
        step_d = step_q;
        launch_seen_d = launch_seen_q;
        rd_seen_d = rd_seen_q;
        out_word_d = out_word_q;
        if (step_q != `SACS_STEP_IDLE && step_q != `SACS_STEP_DONE) begin
            step_d = step_q + 4'h1;
        end
        if (launch_tgl_q != launch_seen_q) begin
            launch_seen_d = launch_tgl_q;
            if (ctrl_word_q[`SACS_CTRL_CLOCK_BIT]) begin // [RULE23]
                step_d = `SACS_STEP_STROBE; // [RULE1]
                out_word_d = fmt_code(code_snap_q, ctrl_word_q[`SACS_CTRL_POLARITY_BIT]);
            end
        end else if (dn_s2_q != rd_seen_q) begin
            // Two rises synchronise completion; MSB leaves on the second fall
            // Limitation: clocking right as the strobe rises delays the MSB
            rd_seen_d = dn_s2_q;
            step_d = `SACS_STEP_MSB; // [RULE8]
            out_word_d = result_q;
        end
        if (sh_s2_q) begin
            step_d = `SACS_STEP_IDLE; // [RULE21]
        end
        // Hold step keeps the pulse only when it began at the strobe step
        ext_strobe_d = (step_d == `SACS_STEP_STROBE) ||
                       (step_d == `SACS_STEP_HOLD && ext_strobe_q); // [RULE1]
        bit_idx = 3'(`SACS_STEP_LSB - step_d);
        dout_d = 1'b0; // [RULE3] [RULE17]
        if (step_d >= `SACS_STEP_MSB && step_d <= `SACS_STEP_LSB) begin
            dout_d = out_word_d[bit_idx]; // [RULE2]
        end
        link_busy_d = (step_d != `SACS_STEP_IDLE) && (step_d != `SACS_STEP_DONE);
    end

    always_ff @(negedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            step_q <= `SACS_STEP_IDLE;
            out_word_q <= `SACS_RESULT_RST;
            dout_q <= 1'b0;
            ext_strobe_q <= 1'b0; // [RULE4]
            link_busy_q <= 1'b0;
        end else begin
            step_q <= step_d;
            out_word_q <= out_word_d;
            dout_q <= dout_d;
            ext_strobe_q <= ext_strobe_d;
            link_busy_q <= link_busy_d;
        end
    end

    always_ff @(negedge serial_clk or posedge reset) begin
        if (reset) begin
            launch_seen_q <= 1'b0;
            rd_seen_q <= 1'b0;
        end else begin
            launch_seen_q <= launch_seen_d;
            rd_seen_q <= rd_seen_d;
        end
    end

    // ****************************************************************
    // Converter domain: internal conversion and power sequencing
    // ****************************************************************
    logic rq_s1_q, rq_s2_q, rq_prev_q;
    logic [2:0] sd_s1_q, sd_s2_q;
    logic xb_s1_q, xb_s2_q, fa_s1_q, fa_s2_q;
    sacs_byte_t ca_s1_q, ca_s2_q;
    sacs_conv_e cv_q, cv_d;
    logic [15:0] cnt_q, cnt_d;
    sacs_byte_t result_d;
    logic done_tgl_d, mode_ext_q, mode_ext_d, pd1_q, pd1_d;
    sacs_byte_t cfg_q, cfg_d;
    logic pwr_q, pwr_d, ref_en_q, ref_en_d, int_strobe_q, int_strobe_d;
    logic new_req, sd_low;

    always_comb begin
        new_req = rq_s2_q != rq_prev_q;
        sd_low = sd_s2_q[0]; // [RULE26]
        cv_d = cv_q;
        cnt_d = cnt_q;
        result_d = result_q;
        done_tgl_d = done_tgl_q;
        mode_ext_d = mode_ext_q;
        pd1_d = pd1_q;
        cfg_d = cfg_q;
        if (new_req) begin
            // Control word stays frozen until the next launch toggle
            cfg_d = ctrl_word_q;
            mode_ext_d = ctrl_word_q[`SACS_CTRL_CLOCK_BIT]; // [RULE23]
            pd1_d = ctrl_word_q[`SACS_CTRL_POWER_BIT]; // [RULE20]
            // A new start replaces any unfinished conversion
            cv_d = ctrl_word_q[`SACS_CTRL_CLOCK_BIT] ? SACS_CV_IDLE : SACS_CV_RUN; // [RULE15]
            cnt_d = 16'h0000;
        end else if (cv_q == SACS_CV_RUN) begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q == 16'(CONV_CYCLES - 1)) begin // [RULE6]
                cv_d = SACS_CV_IDLE;
                result_d = fmt_code(ca_s2_q, cfg_q[`SACS_CTRL_POLARITY_BIT]); // [RULE8]
                done_tgl_d = ~done_tgl_q;
            end
        end
        if (sd_low) begin
            cv_d = SACS_CV_IDLE; // [RULE21]
        end
        int_strobe_d = (cv_d == SACS_CV_IDLE); // [RULE6]
        // Power-down request sleeps only once every running conversion has finished; shutdown low sleeps at once
        pwr_d = !sd_low && (pd1_d || cv_d == SACS_CV_RUN || xb_s2_q || fa_s2_q); // [RULE18] [RULE19]
        ref_en_d = sd_s2_q[2] && !sd_low; // [RULE22]
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rq_s1_q <= 1'b0;
            rq_s2_q <= 1'b0;
            rq_prev_q <= 1'b0;
            sd_s1_q <= 3'h0;
            sd_s2_q <= 3'h0;
            xb_s1_q <= 1'b0;
            xb_s2_q <= 1'b0;
            fa_s1_q <= 1'b0;
            fa_s2_q <= 1'b0;
            ca_s1_q <= `SACS_RESULT_RST;
            ca_s2_q <= `SACS_RESULT_RST;
            cv_q <= SACS_CV_IDLE;
            cnt_q <= 16'h0000;
            result_q <= `SACS_RESULT_RST;
            done_tgl_q <= 1'b0;
            mode_ext_q <= 1'b0; // [RULE17]
            pd1_q <= 1'b1;
            cfg_q <= `SACS_CTRL_RST;
            pwr_q <= 1'b0;
            ref_en_q <= 1'b0;
            int_strobe_q <= 1'b1; // [RULE17]
        end else begin
            rq_s1_q <= launch_tgl_q;
            rq_s2_q <= rq_s1_q;
            rq_prev_q <= rq_s2_q;
            sd_s1_q <= {hard_shutdown_input_float, hard_shutdown_input_high,
                        hard_shutdown_input_low};
            sd_s2_q <= sd_s1_q;
            xb_s1_q <= link_busy_q;
            xb_s2_q <= xb_s1_q;
            fa_s1_q <= (fr_q == SACS_FR_CTRL);
            fa_s2_q <= fa_s1_q;
            ca_s1_q <= analog_code;
            ca_s2_q <= ca_s1_q;
            cv_q <= cv_d;
            cnt_q <= cnt_d;
            result_q <= result_d;
            done_tgl_q <= done_tgl_d;
            mode_ext_q <= mode_ext_d;
            pd1_q <= pd1_d;
            cfg_q <= cfg_d;
            pwr_q <= pwr_d;
            ref_en_q <= ref_en_d;
            int_strobe_q <= int_strobe_d;
        end
    end

    // ****************************************************************
    // Pins
    // ****************************************************************
    assign serial_data_out = dout_q;
    assign serial_data_out_oe = !chip_select_n; // [RULE9]
    assign conversion_strobe = mode_ext_q ? ext_strobe_q : int_strobe_q;
    assign conversion_strobe_oe = !mode_ext_q || !chip_select_n; // [RULE4] [RULE10]
    assign channel_select = cfg_q[`SACS_CTRL_CHAN_HI:`SACS_CTRL_CHAN_LO];
    assign polarity_select = cfg_q[`SACS_CTRL_POLARITY_BIT];
    assign input_config_select = cfg_q[`SACS_CTRL_CONFIG_BIT];
    assign power_up = pwr_q;
    assign reference_enable = ref_en_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_strobe_pulse;
        ext_strobe_q ##1 !ext_strobe_q;
    endsequence

    a_strobe_two_fall: assert property ( // [RULE1]
        @(negedge serial_clk) disable iff (link_rst)
        $rose(ext_strobe_q) |=> s_strobe_pulse)
        else $error("strobe pulse not two clocks wide");

    a_msb_with_strobe_fall: assert property ( // [RULE2]
        @(negedge serial_clk) disable iff (link_rst)
        $fell(ext_strobe_q) && !sh_s2_q |-> dout_q == out_word_q[7])
        else $error("msb not presented as strobe falls");

    a_zeros_after_lsb: assert property ( // [RULE3]
        @(negedge serial_clk) disable iff (link_rst)
        step_q == `SACS_STEP_DONE |-> !dout_q)
        else $error("nonzero bit after result");

    a_select_floats_pins: assert property ( // [RULE4]
        @(posedge ref_clk) disable iff (reset)
        chip_select_n |-> !serial_data_out_oe && (conversion_strobe_oe == !mode_ext_q))
        else $error("output enable wrong while deselected");

    a_conv_ends_on_count: assert property ( // [RULE6]
        @(posedge ref_clk) disable iff (reset)
        cv_q == SACS_CV_RUN && cnt_q == 16'(CONV_CYCLES - 1) && !new_req && !sd_low
        |=> cv_q == SACS_CV_IDLE && int_strobe_q && done_tgl_q != $past(done_tgl_q))
        else $error("internal conversion length wrong");

    a_hard_shutdown_input_halts_conv: assert property ( // [RULE21]
        @(posedge ref_clk) disable iff (reset)
        sd_low |=> cv_q == SACS_CV_IDLE && !power_up)
        else $error("shutdown did not halt conversion");

    a_start_bit_taken: assert property ( // [RULE12]
        @(posedge serial_clk) disable iff (link_rst)
        fr_q == SACS_FR_HUNT && serial_data_in && hunt_ok |=> fr_q == SACS_FR_CTRL)
        else $error("start bit not recognised");

    a_launch_on_eighth: assert property ( // [RULE13]
        @(posedge serial_clk) disable iff (link_rst)
        fr_q == SACS_FR_CTRL && bit_cnt_q == `SACS_CTRL_LAST_CNT
        |=> launch_tgl_q != $past(launch_tgl_q) && fr_q == SACS_FR_HUNT)
        else $error("conversion not launched after eighth bit");

    a_pd_request_sleeps: assert property ( // [RULE19]
        @(posedge ref_clk) disable iff (reset)
        !pd1_q && cv_q == SACS_CV_IDLE && !xb_s2_q && !fa_s2_q && !new_req
        |=> !power_up)
        else $error("device stayed awake after power-down request");

endmodule
`default_nettype wire
